// >>> core/flash_sec_cfg.svh
// Purpose: Offsets, field positions, reset values and limits of the flash
//          security and protection configuration block.
// Assumes: 16-bit CPU address space, 8-bit registers.
// Notes:   Definitions only.
`ifndef FLASH_SEC_CFG_SVH
`define FLASH_SEC_CFG_SVH

// ========================================================================
// Register addresses
`define FSP_ADDR_OPT     16'h1821
`define FSP_ADDR_CFG     16'h1823
`define FSP_ADDR_PROT    16'h1824

// ========================================================================
// Option shadow fields
`define FSP_OPT_KEY_ENABLE    7
`define FSP_OPT_NORED    6
`define FSP_OPT_SEC_HI   1
`define FSP_OPT_SEC_LO   0
`define FSP_OPT_MASK     8'hC3
`define FSP_OPT_RST      8'h00
`define FSP_SEC_UNSEC    2'h2

// ========================================================================
// Configuration control fields
`define FSP_CFG_KEY_ACCESS   5
`define FSP_CFG_MASK     8'hE0
`define FSP_CFG_RST      8'h00

// ========================================================================
// Protection shadow fields
`define FSP_PROT_OPEN    7
`define FSP_PROT_DIS     6
`define FSP_PROT_PS_HI   5
`define FSP_PROT_PS_LO   3
`define FSP_PROT_MASK    8'hF8
`define FSP_PROT_RST     8'h00
`define FSP_PS_ALL       3'h7

// ========================================================================
// Address map constants
`define FSP_KEY_LO       16'hFFB0
`define FSP_KEY_HI       16'hFFB7
`define FSP_KEY_BYTES    4'h8
`define FSP_FLASH_LOW    16'h182C
`define FSP_BLK_MIN      17'h00200
`define FSP_ADDR_TOP     17'h10000
`define FSP_VEC_SPAN     16'h0040
`define FSP_VEC_LO       16'hFFC0
`define FSP_VEC_HI       16'hFFFD

`endif

// >>> core/flash_sec_pkg.sv
// Purpose: Types shared by the flash security and protection block.
// Assumes: Constants come from flash_sec_cfg.svh.
// Notes:   All state of the main module is one packed struct.
`default_nettype none
package flash_sec_pkg;

   // =====================================================================
   // Control sequence
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RUN  = 2'b01
   } seq_state_t;

   // =====================================================================
   // Complete register state
   typedef struct packed {
      seq_state_t  st;
      logic [7:0]  opt;
      logic [7:0]  cfg;
      logic [7:0]  prot;
      logic [63:0] key_buf;
      logic [3:0]  key_idx;
      logic        key_bad;
      logic        viol;
      logic [7:0]  rdata;
      logic        flash_wr;
      logic [15:0] fwr_addr;
      logic [7:0]  fwr_data;
      logic        cmd_ok;
      logic        cmd_bad;
      logic [15:0] vec_addr;
      logic        vec_valid;
      logic        secure;
      logic        redir_en;
      logic [15:0] redir_base;
   } fsp_state_t;

endpackage
`default_nettype wire

// >>> core/protect_range_calc.sv
// Purpose: Decodes the protection and option shadows into the protected
//          range and the vector redirection window.
// Assumes: Purely combinational; caller registers only the redirect enable and base.
// Notes:   Flash smaller than the selected range is clamped to its start.
`timescale 1ns/100ps
`default_nettype none
`include "flash_sec_cfg.svh"

module protect_range_calc #(
   parameter logic [15:0] FLASH_LOW = `FSP_FLASH_LOW
) (
   input  wire logic [7:0]  prot_i,        // Protection shadow
   input  wire logic [7:0]  opt_i,         // Option shadow
   output logic      [15:0] base_o,        // First protected address
   output logic             all_lock_o,    // Whole array locked
   output logic             block_on_o,    // High block protected
   output logic             redir_on_o,    // Vector redirection active
   output logic      [15:0] redir_base_o   // Redirected vector base
);

   logic [2:0]  size_code;
   logic [16:0] span;
   logic [16:0] raw_base;
   logic        clamped;

   always_comb begin
      size_code = prot_i[`FSP_PROT_PS_HI:`FSP_PROT_PS_LO];
      span = `FSP_BLK_MIN << size_code;
      raw_base = `FSP_ADDR_TOP - span;
      all_lock_o = ~prot_i[`FSP_PROT_OPEN];
      block_on_o = ~prot_i[`FSP_PROT_DIS];
      // Code 111 and any range reaching below the array start use the
      // array start itself, the largest range this part can hold.
      clamped = (size_code == `FSP_PS_ALL)
              || (raw_base[15:0] < FLASH_LOW);
      base_o = clamped ? FLASH_LOW : raw_base[15:0];
      redir_base_o = base_o - `FSP_VEC_SPAN;
      // A clamped range has no room below it, so it never redirects.
      redir_on_o = block_on_o && !clamped
                 && prot_i[`FSP_PROT_OPEN]
                 && !opt_i[`FSP_OPT_NORED];
   end

endmodule
`default_nettype wire

// >>> core/flash_security_protection_cfg.sv
// Purpose: Security state, backdoor key unlock and block protection with
//          vector redirection for the on-chip flash.
// Assumes: Nonvolatile bytes and the stored key are stable inputs from the
//          array; bus, command and vector requests are on clk_sys_i.
// Notes:   Shadows load on the first edge after each reset release.
`timescale 1ns/100ps
`default_nettype none
`include "flash_sec_cfg.svh"

// Operation
// - Option shadow is loaded from the nonvolatile option byte on every reset.
// - Option bits 5..2 read zero; option shadow writes are ignored.
// - Key enable clear means the backdoor key can never unlock.
// - Eight matching key bytes in ascending order unlock until next reset.
// - Key writes from background debug never count toward unlocking.
// - Redirect disable bit set stops vector redirection; clear allows it.
// - Only security pattern 10 is unsecured; 00, 01, 11 are secure.
// - While secure, memory accesses from unsecured sources are blocked; this block only reports it on secure_o and blocks nothing.
// - Key match or full blank check turns the security field to 10.
// - Config bits 7..5 read and write; bits 4..0 read zero.
// - Key access set captures key writes; clear passes them as commands.
// - With key access set, flash read data is flagged invalid.
// - Protection shadow is loaded from the nonvolatile byte on every reset.
// - Protection bits 2..0 read zero; user writes are ignored.
// - Background debug writes update the implemented protection bits.
// - Open bit clear forbids all program/erase; set permits unprotected ones.
// - Protect disable set protects nothing; clear protects the sized block.
// - Size code picks block ending at FFFF; 111 reaches down to 182C.
// - Program or erase inside the protected block is refused.
// - Vectors come from just below the protected block; code 111 never.
// - No redirection when open bit is 0 or redirect disable is 1.
// - The reset vector is never redirected.
// - A refused command sets a sticky violation flag and is ignored.
module flash_security_protection_cfg
   import flash_sec_pkg::*;
#(
   parameter logic [15:0] FLASH_LOW = `FSP_FLASH_LOW
) (
   input  wire logic        clk_sys_i,        // Bus clock
   input  wire logic        rstn_i,           // MCU reset, active low

   input  wire logic [7:0]  nv_option_i,      // Nonvolatile option byte
   input  wire logic [7:0]  nv_protect_i,     // Nonvolatile protection byte
   input  wire logic [63:0] stored_key_i,     // Stored key, byte 0 lowest

   input  wire logic [15:0] bus_addr_i,       // CPU bus address
   input  wire logic        bus_wr_i,         // Write strobe
   input  wire logic        bus_rd_i,         // Read strobe
   input  wire logic [7:0]  bus_wdata_i,      // Write data
   input  wire logic        bus_dbg_i,        // Access from debug command

   input  wire logic        blank_pass_i,     // Full blank check passed
   input  wire logic        cmd_launch_i,     // Command launch pulse
   input  wire logic        cmd_mass_i,       // Command is mass erase
   input  wire logic [15:0] cmd_addr_i,       // Command target address
   input  wire logic        viol_clr_i,       // Clear violation flag

   input  wire logic        vec_req_i,        // Vector fetch request
   input  wire logic [15:0] vec_addr_i,       // Vector address requested

   output logic      [7:0]  reg_rdata_o,      // Register read data
   output logic             flash_wr_o,       // Array write to sequencer
   output logic      [15:0] flash_wr_addr_o,  // Array write address
   output logic      [7:0]  flash_wr_data_o,  // Array write data

   output logic             read_invalid_o,   // Flash read data invalid
   output logic             secure_o,         // Device secure

   output logic             cmd_ok_o,         // Command accepted pulse
   output logic             cmd_refused_o,    // Command refused pulse
   output logic             prot_viol_o,      // Sticky violation flag

   output logic             vec_valid_o,      // Vector address valid
   output logic      [15:0] vec_addr_o,       // Vector address to fetch

   output logic             redirect_en_o,    // Redirection active
   output logic      [15:0] redirect_base_o   // Redirect window base
);

   // =====================================================================
   // Helpers
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [7:0] key_byte(input logic [63:0] k,
                                           input logic [2:0]  idx);
      key_byte = k[{idx, 3'h0} +: 8];
   endfunction

   // =====================================================================
   // State
   fsp_state_t r;
   fsp_state_t n;

   logic [15:0] base;
   logic        all_lock;
   logic        block_on;
   logic        redir_on;
   logic [15:0] redir_base;

   protect_range_calc #(
      .FLASH_LOW (FLASH_LOW)
   ) u_range (
      .prot_i       (r.prot),
      .opt_i        (r.opt),
      .base_o       (base),
      .all_lock_o   (all_lock),
      .block_on_o   (block_on),
      .redir_on_o   (redir_on),
      .redir_base_o (redir_base)
   );

   // =====================================================================
   // Next state
   logic       key_access_old;
   logic       key_access_new;
   logic       hit;
   logic [2:0] kidx;

   always_comb begin
      n = r;
      key_access_old = r.cfg[`FSP_CFG_KEY_ACCESS];
      key_access_new = key_access_old;
      hit = 1'b0;
      kidx = bus_addr_i[2:0];

      n.flash_wr = 1'b0;
      n.cmd_ok = 1'b0;
      n.cmd_bad = 1'b0;
      n.vec_valid = 1'b0;
      n.rdata = 8'h00;

      unique case (r.st)
         ST_LOAD: begin
            // Copying in the first clocked cycle keeps the reset itself
            // free of data: the flops only ever reset to constants.
            n.opt = nv_option_i & `FSP_OPT_MASK;
            n.prot = nv_protect_i & `FSP_PROT_MASK;
            n.cfg = `FSP_CFG_RST;
            n.key_idx = 4'h0;
            n.key_bad = 1'b0;
            n.st = ST_RUN;
         end

         ST_RUN: begin
            // Configuration register; key access edges frame a key entry.
            if (bus_wr_i && bus_addr_i == `FSP_ADDR_CFG) begin
               n.cfg = bus_wdata_i & `FSP_CFG_MASK;
               key_access_new = bus_wdata_i[`FSP_CFG_KEY_ACCESS];
               if (!key_access_old && key_access_new) begin
                  n.key_idx = 4'h0;
                  n.key_bad = 1'b0;
               end

               if (key_access_old && !key_access_new) begin
                  hit = r.opt[`FSP_OPT_KEY_ENABLE]
                     && !r.key_bad
                     && r.key_idx == `FSP_KEY_BYTES
                     && r.key_buf == stored_key_i;
                  n.key_idx = 4'h0;
                  n.key_bad = 1'b0;
               end
            end

            // Protection shadow takes debug writes only.
            if (bus_wr_i && bus_dbg_i && bus_addr_i == `FSP_ADDR_PROT) begin
               n.prot = bus_wdata_i & `FSP_PROT_MASK;
            end

            // Option shadow has no write path at all.
            if (bus_wr_i && in_range(bus_addr_i, `FSP_KEY_LO, `FSP_KEY_HI)
                && key_access_old) begin
               // Debug key writes are swallowed without touching the
               // sequence, so they neither help nor spoil an entry.
               if (!bus_dbg_i) begin
                  if (r.key_idx == {1'b0, kidx}) begin
                     n.key_buf[{kidx, 3'h0} +: 8] = bus_wdata_i;
                     if (bus_wdata_i != key_byte(stored_key_i, kidx)) begin
                        n.key_bad = 1'b1;
                     end
                     n.key_idx = r.key_idx + 4'h1;
                  end else begin
                     n.key_bad = 1'b1;
                  end
               end
            end else if (bus_wr_i && bus_addr_i >= FLASH_LOW) begin
               n.flash_wr = 1'b1;
               n.fwr_addr = bus_addr_i;
               n.fwr_data = bus_wdata_i;
            end

            if (hit || blank_pass_i) begin
               n.opt[`FSP_OPT_SEC_HI:`FSP_OPT_SEC_LO] = `FSP_SEC_UNSEC;
            end

            // Register reads; unmapped addresses return zero.
            if (bus_rd_i) begin
               unique case (bus_addr_i)
                  `FSP_ADDR_OPT:  n.rdata = r.opt & `FSP_OPT_MASK;
                  `FSP_ADDR_CFG:  n.rdata = r.cfg & `FSP_CFG_MASK;
                  `FSP_ADDR_PROT: n.rdata = r.prot & `FSP_PROT_MASK;
                  default:        n.rdata = 8'h00;
               endcase
            end

            // Protection check; a set in the clear cycle still wins.
            if (viol_clr_i) begin
               n.viol = 1'b0;
            end

            if (cmd_launch_i) begin
               if (all_lock
                   || (block_on && (cmd_mass_i
                       || cmd_addr_i >= base))) begin
                  n.viol = 1'b1;
                  n.cmd_bad = 1'b1;
               end else begin
                  n.cmd_ok = 1'b1;
               end
            end

            // Vector fetch; the reset vector sits above the window.
            if (vec_req_i) begin
               n.vec_valid = 1'b1;
               if (r.redir_en
                   && in_range(vec_addr_i, `FSP_VEC_LO, `FSP_VEC_HI)) begin
                  n.vec_addr = r.redir_base | {10'h000, vec_addr_i[5:0]};
               end else begin
                  n.vec_addr = vec_addr_i;
               end
            end
         end
      endcase

      n.secure = n.opt[`FSP_OPT_SEC_HI:`FSP_OPT_SEC_LO]
                 != `FSP_SEC_UNSEC;
      n.redir_en = redir_on;
      n.redir_base = redir_base;
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r.st <= ST_LOAD;

         r.opt <= `FSP_OPT_RST;
         r.cfg <= `FSP_CFG_RST;
         r.prot <= `FSP_PROT_RST;

         r.key_buf <= 64'h0000000000000000;
         r.key_idx <= 4'h0;
         r.key_bad <= 1'b0;

         r.viol <= 1'b0;

         r.rdata <= 8'h00;
         r.flash_wr <= 1'b0;
         r.fwr_addr <= 16'h0000;
         r.fwr_data <= 8'h00;

         r.cmd_ok <= 1'b0;
         r.cmd_bad <= 1'b0;
         r.vec_addr <= 16'h0000;
         r.vec_valid <= 1'b0;

         r.secure <= 1'b1;
         r.redir_en <= 1'b0;
         r.redir_base <= 16'h0000;
      end else begin
         r <= n;
      end
   end

   // =====================================================================
   // Outputs
   // Secure is asserted from reset until the shadow says otherwise, so a
   // debug host can never slip an access in before the load.
   assign reg_rdata_o = r.rdata;

   assign flash_wr_o = r.flash_wr;
   assign flash_wr_addr_o = r.fwr_addr;
   assign flash_wr_data_o = r.fwr_data;

   assign read_invalid_o = r.cfg[`FSP_CFG_KEY_ACCESS];
   assign secure_o = r.secure;

   assign cmd_ok_o = r.cmd_ok;
   assign cmd_refused_o = r.cmd_bad;
   assign prot_viol_o = r.viol;

   assign vec_valid_o = r.vec_valid;
   assign vec_addr_o = r.vec_addr;

   assign redirect_en_o = r.redir_en;
   assign redirect_base_o = r.redir_base;

endmodule
`default_nettype wire

// >>> tb/fsp_props.sv
// Purpose: Port-level assertions for the flash security block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
`include "flash_sec_cfg.svh"
// ======================================================================
// Checker
module fsp_props (
   input  wire logic        clk_sys_i,
   input  wire logic        rstn_i,
   input  wire logic [15:0] bus_addr_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   input  wire logic        cmd_launch_i,
   input  wire logic [15:0] cmd_addr_i,
   input  wire logic        viol_clr_i,
   input  wire logic        vec_req_i,
   input  wire logic [15:0] vec_addr_i,
   input  wire logic [7:0]  reg_rdata_o,
   input  wire logic        flash_wr_o,
   input  wire logic [15:0] flash_wr_addr_o,
   input  wire logic        read_invalid_o,
   input  wire logic        cmd_ok_o,
   input  wire logic        cmd_refused_o,
   input  wire logic        prot_viol_o,
   input  wire logic        vec_valid_o,
   input  wire logic [15:0] vec_addr_o,
   input  wire logic        redirect_en_o,
   input  wire logic [15:0] redirect_base_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   opt_rsvd_a: assert property (
      bus_rd_i && bus_addr_i == `FSP_ADDR_OPT |=> reg_rdata_o[5:2] == 4'h0)
      else $error("option reserved bits not zero");
   cfg_rsvd_a: assert property (
      bus_rd_i && bus_addr_i == `FSP_ADDR_CFG |=> reg_rdata_o[4:0] == 5'h00)
      else $error("config low bits not zero");
   prot_rsvd_a: assert property (
      bus_rd_i && bus_addr_i == `FSP_ADDR_PROT |=> reg_rdata_o[2:0] == 3'h0)
      else $error("protection low bits not zero");
   viol_sticky_a: assert property (
      prot_viol_o && !viol_clr_i |=> prot_viol_o)
      else $error("violation flag dropped");
   cmd_answer_a: assert property (
      cmd_launch_i |=> (cmd_ok_o ^ cmd_refused_o) && $stable(prot_viol_o)
      || cmd_refused_o && prot_viol_o)
      else $error("command answer wrong");
   blk_refuse_a: assert property (
      cmd_launch_i && redirect_en_o &&
      {1'b0, cmd_addr_i} >= {1'b0, redirect_base_o} + 17'h00040
      |=> cmd_refused_o) else $error("protected command accepted");
   reset_vec_a: assert property (
      vec_req_i && vec_addr_i[15:1] == 15'h7FFF
      |=> vec_valid_o && vec_addr_o == $past(vec_addr_i))
      else $error("reset vector moved");
   redir_vec_a: assert property (
      vec_req_i && redirect_en_o &&
      vec_addr_i inside {[`FSP_VEC_LO:`FSP_VEC_HI]}
      |=> vec_addr_o == ($past(redirect_base_o) | ($past(vec_addr_i) &
      16'h003F))) else $error("vector not redirected");
   no_redir_a: assert property (
      vec_req_i && !redirect_en_o |=> vec_addr_o == $past(vec_addr_i))
      else $error("vector redirected while off");
   key_nofwd_a: assert property (
      bus_wr_i && read_invalid_o && bus_addr_i inside
      {[`FSP_KEY_LO:`FSP_KEY_HI]} |=> !flash_wr_o)
      else $error("key write forwarded");
   flash_fwd_a: assert property (
      bus_wr_i && !read_invalid_o && bus_addr_i >= `FSP_FLASH_LOW
      |=> flash_wr_o && flash_wr_addr_o == $past(bus_addr_i))
      else $error("flash write not forwarded");
endmodule

bind flash_security_protection_cfg fsp_props i_fsp_props (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_addr_i(bus_addr_i),
   .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .cmd_launch_i(cmd_launch_i),
   .cmd_addr_i(cmd_addr_i), .viol_clr_i(viol_clr_i),
   .vec_req_i(vec_req_i), .vec_addr_i(vec_addr_i),
   .reg_rdata_o(reg_rdata_o), .flash_wr_o(flash_wr_o),
   .flash_wr_addr_o(flash_wr_addr_o), .read_invalid_o(read_invalid_o),
   .cmd_ok_o(cmd_ok_o), .cmd_refused_o(cmd_refused_o),
   .prot_viol_o(prot_viol_o), .vec_valid_o(vec_valid_o),
   .vec_addr_o(vec_addr_o), .redirect_en_o(redirect_en_o),
   .redirect_base_o(redirect_base_o));
`default_nettype wire

// >>> tb/bus_host_model.sv
// Purpose: CPU and background debug host driving the register bus.
// Assumes: Requests are taken on the edge after they are presented.
// Notes:   A released bus shows inverted address and data, never the last ones; dbg_o keeps its last value.
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Bus host
module bus_host_model (
   input  wire logic        clk_sys_i, // Bus clock
   input  wire logic [7:0]  rdata_i,   // Read data from block
   output logic      [15:0] addr_o,    // Address
   output logic             wr_o,      // Write strobe
   output logic             rd_o,      // Read strobe
   output logic      [7:0]  wdata_o,   // Write data
   output logic             dbg_o      // Access from debug host
);
   initial begin
      addr_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
      dbg_o = 1'b0;
   end

   // One transfer; read data is taken in the cycle after the strobe.
   task automatic xfer(input logic r, input logic [15:0] a,
                       input logic [7:0] d, input logic g,
                       output logic [7:0] q);
      @(posedge clk_sys_i);
      #1;
      addr_o = a;
      wdata_o = d;
      dbg_o = g;
      rd_o = r;
      wr_o = !r;
      @(posedge clk_sys_i);
      #1;
      q = rdata_i;
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule
`default_nettype wire

// >>> tb/flash_security_protection_cfg_bench.sv
// Purpose: Self-checking bench for the flash security block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Each reset reloads the shadows from the nonvolatile bytes.
`timescale 1ns/100ps
`default_nettype none
`include "flash_sec_cfg.svh"
module flash_security_protection_cfg_bench;
   logic        clk_sys_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [7:0]  nv_opt = 8'h00, nv_prot = 8'h00, rdata, wdata, fwd;
   logic [63:0] key = 64'h8877665544332211;
   logic [15:0] bus_addr, fwa, vaddr, rbase;
   logic [15:0] cmd_addr = 16'h0000, vec_addr = 16'h0000;
   logic        wr, rd, dbg, fwr, rinv, sec, ok, refd, viol, vval, ren;
   logic        blank = 1'b0, launch = 1'b0, mass = 1'b0;
   logic        vclr = 1'b0, vreq_s = 1'b0;
   int          n_fail = 0, num_checks = 0;

   flash_security_protection_cfg i_flash_security_protection_cfg (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .nv_option_i(nv_opt),
      .nv_protect_i(nv_prot), .stored_key_i(key), .bus_addr_i(bus_addr),
      .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_dbg_i(dbg),
      .blank_pass_i(blank), .cmd_launch_i(launch), .cmd_mass_i(mass),
      .cmd_addr_i(cmd_addr), .viol_clr_i(vclr), .vec_req_i(vreq_s),
      .vec_addr_i(vec_addr), .reg_rdata_o(rdata), .flash_wr_o(fwr),
      .flash_wr_addr_o(fwa), .flash_wr_data_o(fwd),
      .read_invalid_o(rinv), .secure_o(sec), .cmd_ok_o(ok),
      .cmd_refused_o(refd), .prot_viol_o(viol), .vec_valid_o(vval),
      .vec_addr_o(vaddr), .redirect_en_o(ren), .redirect_base_o(rbase));

   bus_host_model i_bus_host_model (
      .clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(bus_addr),
      .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .dbg_o(dbg));

   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // ===================================================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic step;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
      step();
      nv_opt = o;
      nv_prot = p;
      rstn_i = 1'b0;
      repeat (2) step();
      rstn_i = 1'b1;
      repeat (2) step();
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      i_bus_host_model.xfer(1'b1, a, 8'h00, 1'b0, q);
      chk({8'h00, q}, {8'h00, e});
   endtask
   task automatic wr_do(input logic [15:0] a, input logic [7:0] d,
                        input logic g);
      logic [7:0] q;
      i_bus_host_model.xfer(1'b0, a, d, g, q);
   endtask
   task automatic cmd(input logic [15:0] a, input logic m, input logic r);
      step();
      cmd_addr = a;
      mass = m;
      launch = 1'b1;
      step();
      launch = 1'b0;
      chk(16'({ok, refd}), r ? 16'h0001 : 16'h0002);
   endtask
   task automatic vreq(input logic [15:0] a, input logic [15:0] e);
      step();
      vec_addr = a;
      vreq_s = 1'b1;
      step();
      vreq_s = 1'b0;
      chk(vaddr, e);
      chk(16'(vval), 16'h0001);
   endtask

   // ===================================================================
   // Scenarios
   task automatic t_regs;
      do_reset(8'hFF, 8'hFF);
      rd_chk(`FSP_ADDR_OPT, 8'hC3);
      wr_do(`FSP_ADDR_OPT, 8'h00, 1'b0);
      rd_chk(`FSP_ADDR_OPT, 8'hC3);
      rd_chk(`FSP_ADDR_PROT, 8'hF8);
      wr_do(`FSP_ADDR_PROT, 8'h00, 1'b0);
      rd_chk(`FSP_ADDR_PROT, 8'hF8);
      wr_do(`FSP_ADDR_PROT, 8'h47, 1'b1);
      rd_chk(`FSP_ADDR_PROT, 8'h40);
      wr_do(`FSP_ADDR_CFG, 8'hFF, 1'b0);
      rd_chk(`FSP_ADDR_CFG, 8'hE0);
      chk(16'(rinv), 16'h0001);
      wr_do(`FSP_ADDR_CFG, 8'h00, 1'b0);
      chk(16'(rinv), 16'h0000);
      wr_do(16'hFFB3, 8'h5A, 1'b0);
      chk({fwa[7:0], fwd}, 16'hB35A);
      rd_chk(16'h1822, 8'h00);
      chk(16'(sec), 16'h0001);
      $display("regs done");
   endtask
   task automatic t_sec;
      for (int i = 0; i < 4; i++) begin
         do_reset(8'(i), 8'h00);
         chk(16'(sec), 16'(i != 2));
      end
      do_reset(8'h00, 8'h00);
      step();
      blank = 1'b1;
      step();
      blank = 1'b0;
      step();
      chk(16'(sec), 16'h0000);
      $display("sec done");
   endtask
   task automatic key_try(input logic [7:0] o, input logic g,
                          input logic sw, input logic e);
      logic [7:0] x;
      int         j;
      x = o & `FSP_OPT_MASK;
      if (!e) begin
         x[1:0] = `FSP_SEC_UNSEC;
      end
      do_reset(o, 8'h00);
      wr_do(`FSP_ADDR_CFG, 8'h20, 1'b0);
      for (int i = 0; i < 8; i++) begin
         j = (sw && i < 2) ? 1 - i : i;
         wr_do(`FSP_KEY_LO + 16'(j), key[8*j +: 8], g);
         if (!g) begin
            chk(16'(fwr), 16'h0000);
         end
      end
      wr_do(`FSP_ADDR_CFG, 8'h00, 1'b0);
      chk(16'(sec), 16'(e));
      rd_chk(`FSP_ADDR_OPT, x);
   endtask
   task automatic t_cmd;
      logic [16:0] b;
      do_reset(8'h02, 8'h00);
      cmd(16'h2000, 1'b0, 1'b1);
      chk(16'(viol), 16'h0001);
      step();
      vclr = 1'b1;
      step();
      vclr = 1'b0;
      chk(16'(viol), 16'h0000);
      for (int c = 0; c < 7; c++) begin
         do_reset(8'h02, 8'h80 | 8'(c << 3));
         b = 17'h10000 - (17'h00200 << c);
         cmd(b[15:0], 1'b0, 1'b1);
         cmd(b[15:0] - 16'h0001, 1'b0, 1'b0);
      end
      cmd(16'h2000, 1'b1, 1'b1);
      do_reset(8'h02, 8'hB8);
      cmd(`FSP_FLASH_LOW, 1'b0, 1'b1);
      do_reset(8'h02, 8'hC0);
      cmd(16'hFFFF, 1'b0, 1'b0);
      $display("cmd done");
   endtask
   task automatic t_vec;
      logic [16:0] b;
      for (int c = 0; c < 7; c++) begin
         do_reset(8'h02, 8'h80 | 8'(c << 3));
         b = 17'h10000 - (17'h00200 << c) - 17'h00040;
         vreq(16'hFFFC, b[15:0] | 16'h003C);
         chk(rbase, b[15:0]);
      end
      vreq(16'hFFFE, 16'hFFFE);
      do_reset(8'h42, 8'h80);
      chk(16'(ren), 16'h0000);
      vreq(16'hFFFC, 16'hFFFC);
      do_reset(8'h02, 8'h00);
      vreq(16'hFFFC, 16'hFFFC);
      do_reset(8'h02, 8'hB8);
      vreq(16'hFFFC, 16'hFFFC);
      $display("vec done");
   endtask

   initial begin
      #2000000;
      n_fail++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk_sys_i);
      t_regs();
      t_sec();
      key_try(8'h81, 1'b0, 1'b0, 1'b0);
      key_try(8'h81, 1'b1, 1'b0, 1'b1);
      key_try(8'h01, 1'b0, 1'b0, 1'b1);
      key_try(8'h81, 1'b0, 1'b1, 1'b1);
      $display("key done");
      t_cmd();
      t_vec();
      test_done();
   end
endmodule
`default_nettype wire
